/* File: common/fb_cond_defines.svh */
// Register map, field positions, reset values and scaling for feedback conditioning
`ifndef FB_COND_DEFINES_SVH
`define FB_COND_DEFINES_SVH

// Percent values are signed Q8.8 in 16 bits: 100 % = 0x6400
`define FS_POS        16'sh6400
`define FS_NEG        -16'sh6400
`define GAIN_ONE      16'h0100

// Register byte offsets
`define A_CTRL        12'h000
`define A_OFFSET      12'h004
`define A_GAIN        12'h008
`define A_SENSOR      12'h00c
`define A_COMMAND     12'h010
`define A_COIL_A      12'h014
`define A_COIL_B      12'h018
`define A_DESIRED     12'h01c
`define A_TAP_POL     12'h020
`define A_TAP_OFS     12'h024
`define A_TAP_GAIN    12'h028
`define A_FEEDBACK    12'h02c
`define A_LAG         12'h030
`define A_STATUS      12'h034
`define A_NODE_BASE   12'h040
`define A_NODE_LAST   12'h060

// CTRL fields
`define CTRL_CFG_LSB  0
`define CTRL_POL_LSB  2
`define CTRL_RNG_LSB  4
`define CTRL_LIN_BIT  6

// Reset values
`define CTRL_RST      32'h0000_0000
`define GAIN_RST      16'h0100

`endif

/* File: common/fb_cond_pkg.sv */
// Types for the feedback conditioning block
package fb_cond_pkg;

	typedef enum logic [1:0] {
		open_loop_config         = 2'b00,
		internal_feedback_config = 2'b01,
		external_feedback_config = 2'b10,
		cascade_feedback_config  = 2'b11
	} config_t;

	typedef enum logic [1:0] {
		pol_off      = 2'b00,
		pol_positive = 2'b01,
		pol_negative = 2'b10
	} polarity_t;

	typedef enum logic [1:0] {
		range_0_10v  = 2'b00,
		range_0_20ma = 2'b01,
		range_4_20ma = 2'b10
	} sensor_range_t;

	// Node point in percent, Q8.8
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
	} node_t;

	// Intermediate values of the chain
	typedef struct packed {
		logic signed [15:0] polarity;
		logic signed [15:0] offset;
		logic signed [15:0] gain;
		logic signed [15:0] feedback;
		logic signed [15:0] lag;
	} taps_t;

endpackage : fb_cond_pkg

/* File: hdl/node_mem.sv */
// Nine-entry node table with a write port and two registered read ports
module node_mem
	import fb_cond_pkg::*;
#(
	parameter int NODES = 9,
	parameter int AW    = 4
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire node_t         wdata,
	// Read ports
	input  wire logic [AW-1:0] raddr_a,
	input  wire logic [AW-1:0] raddr_b,
	output node_t              rdata_a,
	output node_t              rdata_b
);

	node_t mem_q [NODES];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NODES; i++) begin
				mem_q[i] <= '0;
			end
		end else if (we && (int'(waddr) < NODES)) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= (int'(raddr_a) < NODES) ? mem_q[raddr_a] : '0;
			rdata_b <= (int'(raddr_b) < NODES) ? mem_q[raddr_b] : '0;
		end
	end

endmodule : node_mem

/* File: hdl/lin_interp.sv */
// Piecewise linear interpolation between two node points, one-cycle latency
`include "fb_cond_defines.svh"
module lin_interp
	import fb_cond_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Operands
	input  wire logic               start,
	input  wire logic signed [15:0] x_in,
	input  wire node_t              lo,
	input  wire node_t              hi,
	// Result
	output logic                    done,
	output logic signed [15:0]      y_out
);

	logic signed [16:0] dx;
	logic signed [16:0] dy;
	logic signed [16:0] px;
	logic signed [33:0] prod;
	logic signed [33:0] quot;
	logic signed [33:0] sum;

	always_comb begin
		dx   = 17'(hi.x) - 17'(lo.x);
		dy   = 17'(hi.y) - 17'(lo.y);
		px   = 17'(x_in) - 17'(lo.x);
		prod = 34'(px) * 34'(dy);
		quot = (dx > 17'sd0) ? prod / 34'(dx) : 34'sd0;
		sum  = 34'(lo.y) + quot;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done  <= 1'b0;
			y_out <= '0;
		end else begin
			done <= start;
			if (start) begin
				if (sum > 34'(`FS_POS)) begin
					y_out <= `FS_POS;
				end else if (sum < 34'(`FS_NEG)) begin
					y_out <= `FS_NEG;
				end else begin
					y_out <= sum[15:0];
				end
			end
		end
	end

endmodule : lin_interp

/* File: hdl/fb_cond.sv */
// Feedback conditioning chain with AHB-Lite register access
`include "fb_cond_defines.svh"

module fb_cond
	import fb_cond_pkg::*;
#(
	parameter int RAW_W = 12
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [11:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	// External sensor raw sample, same clock domain
	input  wire logic                     sample_valid,
	input  wire logic [RAW_W-1:0]         sample_raw,
	// Internal position sensor, percent
	input  wire logic signed [15:0]       int_position,
	// Setpoint and observed quantities from the controller side
	input  wire logic signed [15:0]       desired_value,
	input  wire logic signed [15:0]       command_signal,
	input  wire logic [15:0]              coil_a_ma,
	input  wire logic [15:0]              coil_b_ma,
	// Conditioned feedback to the difference stage
	output logic                          fb_valid,
	output logic signed [15:0]            fb_value,
	output logic signed [15:0]            lag_error
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic signed [15:0] sat(input logic signed [35:0] v);
		if (v > 36'(`FS_POS)) begin
			return `FS_POS;
		end else if (v < 36'(`FS_NEG)) begin
			return `FS_NEG;
		end
		return v[15:0];
	endfunction : sat

	function automatic logic is_feedback(input config_t c);
		return c != open_loop_config;
	endfunction : is_feedback

	function automatic logic is_external(input config_t c);
		return (c == external_feedback_config) || (c == cascade_feedback_config);
	endfunction : is_external

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [31:0]        ctrl_q;
	logic signed [15:0] offset_q;
	logic [15:0]        gain_q;
	logic [11:0]        waddr_q;
	logic               wpend_q;
	logic [11:0]        raddr;
	logic               rd_req;
	node_t              node_wdata;
	logic [3:0]         node_waddr;
	logic               node_we;

	config_t       cfg;
	polarity_t     pol;
	sensor_range_t rng;
	logic          lin_en;

	assign cfg    = config_t'(ctrl_q[`CTRL_CFG_LSB +: 2]);
	assign pol    = polarity_t'(ctrl_q[`CTRL_POL_LSB +: 2]);
	assign rng    = sensor_range_t'(ctrl_q[`CTRL_RNG_LSB +: 2]);
	assign lin_en = ctrl_q[`CTRL_LIN_BIT];

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign rd_req    = hsel && hready && htrans[1] && !hwrite;
	assign raddr     = haddr;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wpend_q <= 1'b0;
			waddr_q <= '0;
		end else if (hready) begin
			wpend_q <= hsel && htrans[1] && hwrite;
			waddr_q <= haddr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q   <= `CTRL_RST;
			offset_q <= '0;
			gain_q   <= `GAIN_RST;
		end else if (wpend_q) begin
			unique case (waddr_q)
				`A_CTRL:   ctrl_q   <= hwdata & 32'h0000_007f;
				`A_OFFSET: offset_q <= hwdata[15:0];
				`A_GAIN:   gain_q   <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	assign node_we    = wpend_q && (waddr_q >= `A_NODE_BASE) && (waddr_q <= `A_NODE_LAST);
	assign node_waddr = 4'((waddr_q - `A_NODE_BASE) >> 2);
	assign node_wdata = hwdata;

	// ------------------------------------------------------------
	// Range scaling
	// ------------------------------------------------------------
	logic signed [35:0] scaled;
	logic signed [15:0] span_pct;
	localparam logic [RAW_W-1:0] RAW_FULL = {RAW_W{1'b1}};
	localparam logic [RAW_W-1:0] RAW_4MA  = RAW_W'((2**RAW_W - 1) / 5);

	always_comb begin
		scaled = '0;
		unique case (rng)
			range_4_20ma: begin
				scaled = (signed'(36'(sample_raw)) - signed'(36'(RAW_4MA))) * 36'(`FS_POS)
					/ signed'(36'(RAW_FULL - RAW_4MA));
			end
			default: begin
				scaled = 36'(sample_raw) * 36'(`FS_POS) / 36'(RAW_FULL);
			end
		endcase
		span_pct = sat(scaled);
	end

	// ------------------------------------------------------------
	// Polarity, offset and gain stages
	// ------------------------------------------------------------
	logic signed [15:0] pol_q;
	logic signed [15:0] ofs_q;
	logic signed [15:0] gain_out_q;
	logic [2:0]         stage_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= {stage_q[1:0], sample_valid};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pol_q <= '0;
		end else if (sample_valid) begin
			if (!is_external(cfg)) begin
				pol_q <= int_position;
			end else begin
				unique case (pol)
					pol_positive: pol_q <= span_pct;
					pol_negative: pol_q <= sat(-36'(span_pct));
					default:      pol_q <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ofs_q <= '0;
		end else if (stage_q[0]) begin
			ofs_q <= is_external(cfg) ? sat(36'(pol_q) + 36'(offset_q)) : pol_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gain_out_q <= '0;
		end else if (stage_q[1]) begin
			gain_out_q <= sat((36'(ofs_q) * 36'(signed'({1'b0, gain_q}))) >>> 8);
		end
	end

	// ------------------------------------------------------------
	// Linearization: node search then interpolation
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		lin_idle = 2'b00,
		lin_read = 2'b01,
		lin_calc = 2'b10,
		lin_wait = 2'b11
	} lin_state_t;

	lin_state_t         lstate_q;
	logic [3:0]         idx_q;
	logic signed [15:0] lin_x_q;
	node_t              nd_a;
	node_t              nd_b;
	logic               ip_start;
	logic               ip_done;
	logic signed [15:0] ip_y;
	logic               lin_active;

	assign lin_active = lin_en && is_feedback(cfg);

	node_mem #(
		.NODES (9),
		.AW    (4)
	) u_nodes (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (node_we),
		.waddr   (node_waddr),
		.wdata   (node_wdata),
		.raddr_a (idx_q),
		.raddr_b (idx_q + 4'h1),
		.rdata_a (nd_a),
		.rdata_b (nd_b)
	);

	assign ip_start = (lstate_q == lin_calc);

	lin_interp u_interp (
		.clk   (clk),
		.rst_n (rst_n),
		.start (ip_start),
		.x_in  (lin_x_q),
		.lo    (nd_a),
		.hi    (nd_b),
		.done  (ip_done),
		.y_out (ip_y)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lstate_q <= lin_idle;
			idx_q    <= '0;
			lin_x_q  <= '0;
		end else begin
			unique case (lstate_q)
				lin_idle: begin
					if (stage_q[2] && lin_active) begin
						lin_x_q  <= gain_out_q;
						idx_q    <= '0;
						lstate_q <= lin_read;
					end
				end
				lin_read: lstate_q <= lin_calc;
				lin_calc: begin
					if (lin_x_q > nd_b.x && idx_q < 4'h7) begin
						idx_q    <= idx_q + 4'h1;
						lstate_q <= lin_read;
					end
				end
				lin_wait: lstate_q <= lin_idle;
			endcase
			if (lstate_q == lin_calc && !(lin_x_q > nd_b.x && idx_q < 4'h7)) begin
				lstate_q <= lin_wait;
			end
		end
	end

	// ------------------------------------------------------------
	// Output to the difference stage
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fb_valid  <= 1'b0;
			fb_value  <= '0;
			lag_error <= '0;
		end else begin
			fb_valid <= 1'b0;
			if (lin_active && ip_done && lstate_q == lin_wait) begin
				fb_valid  <= 1'b1;
				fb_value  <= ip_y;
				lag_error <= sat(36'(desired_value) - 36'(ip_y));
			end else if (!lin_active && stage_q[2] && is_feedback(cfg)) begin
				fb_valid  <= 1'b1;
				fb_value  <= gain_out_q;
				lag_error <= sat(36'(desired_value) - 36'(gain_out_q));
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [31:0] rd_d;
	always_comb begin
		rd_d = '0;
		unique case (raddr)
			`A_CTRL:     rd_d = ctrl_q;
			`A_OFFSET:   rd_d = {16'h0000, offset_q};
			`A_GAIN:     rd_d = {16'h0000, gain_q};
			`A_SENSOR:   rd_d = {16'h0000, span_pct};
			`A_COMMAND:  rd_d = {16'h0000, command_signal};
			`A_COIL_A:   rd_d = {16'h0000, coil_a_ma};
			`A_COIL_B:   rd_d = {16'h0000, coil_b_ma};
			`A_DESIRED:  rd_d = is_feedback(cfg) ? {16'h0000, desired_value} : 32'h0;
			`A_FEEDBACK: rd_d = is_feedback(cfg) ? {16'h0000, fb_value} : 32'h0;
			`A_LAG:      rd_d = is_feedback(cfg) ? {16'h0000, lag_error} : 32'h0;
			`A_TAP_POL:  rd_d = {16'h0000, pol_q};
			`A_TAP_OFS:  rd_d = {16'h0000, ofs_q};
			`A_TAP_GAIN: rd_d = {16'h0000, gain_out_q};
			`A_STATUS:   rd_d = {29'h0, lin_active, lstate_q != lin_idle, fb_valid};
			default:     rd_d = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= '0;
		end else if (rd_req) begin
			hrdata <= rd_d;
		end
	end

endmodule : fb_cond

/* File: testbench/fb_cond_sva.sv */
// Port checks for the feedback conditioning chain
`include "fb_cond_defines.svh"
module fb_cond_sva
	import fb_cond_pkg::*;
#(
	parameter int RAW_W = 12
) (
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// Bus
	input wire logic               hsel,
	input wire logic [11:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic               hreadyout,
	input wire logic               hresp,
	// Stream
	input wire logic               sample_valid,
	input wire logic signed [15:0] desired_value,
	input wire logic               fb_valid,
	input wire logic signed [15:0] fb_value,
	input wire logic signed [15:0] lag_error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Control word seen on the bus
	// ----------------------------------------
	logic       ctrl_wr_q;
	logic [6:0] ctrl_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_wr_q <= 1'b0;
			ctrl_q    <= 7'h00;
		end else begin
			ctrl_wr_q <= hsel && hready && htrans[1] && hwrite && haddr == `A_CTRL;
			if (ctrl_wr_q) begin
				ctrl_q <= hwdata[6:0];
			end
		end
	end

	function automatic logic signed [15:0] sat_diff(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		d = {a[15], a} - {b[15], b};
		if (d > 17'sh06400) return 16'sh6400;
		if (d < -17'sh06400) return -16'sh6400;
		return d[15:0];
	endfunction : sat_diff

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_ready_high: assert property (hreadyout)
		else $error("bus slave not ready");
	chk_resp_okay: assert property (!hresp)
		else $error("bus response not okay");
	chk_fb_latency: assert property (sample_valid && ctrl_q[1] && !ctrl_q[6] |=>
		!fb_valid [*3] ##1 fb_valid) else $error("feedback latency wrong");
	chk_lin_window: assert property (sample_valid && ctrl_q[1] && ctrl_q[6] |=>
		!fb_valid [*6] ##[1:15] fb_valid) else $error("linearized feedback timing wrong");
	chk_fb_pulse: assert property (fb_valid |=> !fb_valid)
		else $error("feedback strobe longer than one cycle");
	chk_open_silent: assert property ((ctrl_q[1:0] == 2'b00) [*8] |-> !fb_valid)
		else $error("feedback produced in open loop");
	chk_lag_value: assert property (fb_valid |->
		lag_error == sat_diff(desired_value, fb_value)) else $error("lag error wrong");
	chk_fb_range: assert property (fb_valid |->
		fb_value <= 16'sh6400 && fb_value >= -16'sh6400) else $error("feedback out of range");
	chk_fb_hold: assert property (!fb_valid |-> $stable(fb_value))
		else $error("feedback changed without strobe");

	cover property (sample_valid ##4 fb_valid);
	cover property (fb_valid && fb_value == 16'sh6400);
	cover property (fb_valid && ctrl_q[6]);
endmodule : fb_cond_sva

/* File: testbench/fb_sensor_model.sv */
// Behavioural external feedback sensor
module fb_sensor_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Request from the bench
	input  wire logic        fire,
	input  wire logic [11:0] code,
	// Sensor output
	output logic             sample_valid,
	output logic [11:0]      sample_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	// Raw code only means something with the strobe, so it toggles otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_valid <= 1'b0;
			sample_raw   <= 12'h5a5;
		end else begin
			sample_valid <= fire;
			sample_raw   <= fire ? code : ~sample_raw;
		end
	end
endmodule : fb_sensor_model

/* File: testbench/testbench.sv */
// Self-checking bench for the feedback conditioning chain
`include "fb_cond_defines.svh"
module testbench import fb_cond_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk, rst_n, hsel, hwrite, hreadyout, hresp, fire, sample_valid, fb_valid;
	logic [11:0]        haddr, code, sample_raw;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [31:0]        hwdata, hrdata, rd;
	logic signed [15:0] int_position, desired_value, command_signal, fb_value, lag_error;
	logic [15:0]        coil_a_ma, coil_b_ma;
	int                 failures, compares, i, k, n;
	typedef struct {logic [6:0] ctrl; logic [15:0] ofs, gain, pos, exp; logic [11:0] raw;} row_t;
	// Config, offset, gain, internal position, expected feedback, raw code
	row_t rows[12] = '{'{7'h06, 16'h0a00, 16'h0200, 16'h0, 16'h1400, 12'h0},
		'{7'h0a, 16'hec00, 16'h0100, 16'h0, 16'hec00, 12'h0},
		'{7'h07, 16'h5000, 16'h0200, 16'h0, 16'h6400, 12'h0},
		'{7'h0b, 16'hb000, 16'h0200, 16'h0, 16'h9c00, 12'h0},
		'{7'h02, 16'h0000, 16'h0100, 16'h0, 16'h0000, 12'h800},
		'{7'h05, 16'h0a00, 16'h0100, 16'h1e00, 16'h1e00, 12'h0},
		'{7'h06, 16'hec00, 16'h0100, 16'h0, 16'h0000, 12'h333},
		'{7'h16, 16'h0000, 16'h00c0, 16'h0, 16'h4b00, 12'hfff},
		'{7'h26, 16'h0000, 16'h0100, 16'h0, 16'h3200, 12'h999},
		'{7'h46, 16'h1e00, 16'h0100, 16'h0, 16'h0c80, 12'h0},
		'{7'h46, 16'h3c00, 16'h0100, 16'h0, 16'h2d00, 12'h0},
		'{7'h57, 16'hbf00, 16'h0100, 16'h0, 16'hf100, 12'h0}};
	logic [31:0] nodes[9] = '{32'h9e00_c400, 32'ha600_dd00, 32'hbf00_f100, 32'he200_fb00,
		32'h0, 32'h1400_0500, 32'h2800_1400, 32'h3c00_2d00, 32'h5000_5000};

	fb_cond #(.RAW_W(12)) fb_cond_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
		.sample_raw(sample_raw), .int_position(int_position), .desired_value(desired_value),
		.command_signal(command_signal), .coil_a_ma(coil_a_ma), .coil_b_ma(coil_b_ma),
		.fb_valid(fb_valid), .fb_value(fb_value), .lag_error(lag_error));
	fb_sensor_model fb_sensor_model_i (.clk(clk), .rst_n(rst_n), .fire(fire), .code(code),
		.sample_valid(sample_valid), .sample_raw(sample_raw));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report;
		if (failures == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic sample(input logic [11:0] c);
		code <= c;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		for (i = 0; i < 40 && fb_valid !== 1'b1; i++) @(posedge clk);
		chk({15'h0, fb_valid}, 16'h0001);
	endtask : sample

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		final_report();
	end

	initial begin
		{rst_n, hsel, hwrite, fire, haddr, code, htrans, hwdata, int_position} = '0;
		hsize = 3'b010;
		desired_value = 16'sh1000;
		command_signal = 16'sh2a00;
		coil_a_ma = 16'h0123;
		coil_b_ma = 16'h0456;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 9; k++) bus(1'b1, `A_NODE_BASE + 12'(4 * k), nodes[k]);
		for (k = 0; k < 12; k++) begin
			int_position <= rows[k].pos;
			bus(1'b1, `A_OFFSET, {16'h0, rows[k].ofs});
			bus(1'b1, `A_GAIN, {16'h0, rows[k].gain});
			bus(1'b1, `A_CTRL, {25'h0, rows[k].ctrl});
			repeat (4) @(posedge clk);
			sample(rows[k].raw);
			chk(fb_value, rows[k].exp);
			repeat (25) @(posedge clk);
			bus(1'b0, `A_FEEDBACK, 32'h0);
			chk(rd[15:0], rows[k].exp);
		end
		bus(1'b0, `A_TAP_OFS, 32'h0);
		chk(rd[15:0], 16'hbf00);
		bus(1'b0, `A_COMMAND, 32'h0);
		chk(rd[15:0], 16'h2a00);
		bus(1'b0, `A_COIL_A, 32'h0);
		chk(rd[15:0], 16'h0123);
		bus(1'b0, `A_COIL_B, 32'h0);
		chk(rd[15:0], 16'h0456);
		bus(1'b0, `A_DESIRED, 32'h0);
		chk(rd[15:0], 16'h1000);
		bus(1'b0, `A_LAG, 32'h0);
		chk(rd[15:0], 16'h1f00);
		bus(1'b0, `A_TAP_GAIN, 32'h0);
		chk(rd[15:0], 16'hbf00);
		bus(1'b0, `A_STATUS, 32'h0);
		chk(rd[15:0], 16'h0004);
		// Unmapped place ignores writes and reads zero
		bus(1'b1, 12'h100, 32'hffff_ffff);
		bus(1'b0, 12'h100, 32'h0);
		chk(rd[31:16] | rd[15:0], 16'h0);
		// Open loop with the linearizer requested
		bus(1'b1, `A_CTRL, 32'h0000_0044);
		repeat (4) @(posedge clk);
		code <= 12'h0;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		n = 0;
		repeat (30) begin
			@(posedge clk);
			n += fb_valid;
		end
		chk(16'(n), 16'h0);
		bus(1'b0, `A_DESIRED, 32'h0);
		chk(rd[15:0], 16'h0);
		// Second reset restores defaults
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(fb_value, 16'h0);
		bus(1'b0, `A_CTRL, 32'h0);
		chk(rd[15:0], 16'h0);
		bus(1'b0, `A_GAIN, 32'h0);
		chk(rd[15:0], `GAIN_RST);
		bus(1'b0, `A_NODE_BASE, 32'h0);
		chk(rd[15:0], 16'h0);
		// Cleared nodes flatten the linearized output to zero
		bus(1'b1, `A_OFFSET, 32'h0000_1e00);
		bus(1'b1, `A_CTRL, 32'h0000_0046);
		repeat (4) @(posedge clk);
		sample(12'h0);
		chk(fb_value, 16'h0);
		final_report();
	end
endmodule : testbench

bind fb_cond fb_cond_sva #(.RAW_W(RAW_W)) fb_cond_sva_i (.clk(clk), .rst_n(rst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
	.desired_value(desired_value), .fb_valid(fb_valid), .fb_value(fb_value),
	.lag_error(lag_error));
